// [adc_seq_pkg.sv]
// Package: register map, field positions, reset values and timing constants
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package adc_seq_pkg;
    localparam logic [15:0] CTRL_OFFSET  = 16'h1030;
    localparam logic [15:0] RES1_OFFSET  = 16'h1031;
    localparam logic [15:0] RES2_OFFSET  = 16'h1032;
    localparam logic [15:0] RES3_OFFSET  = 16'h1033;
    localparam logic [15:0] RES4_OFFSET  = 16'h1034;
    localparam logic [15:0] OPT_OFFSET   = 16'h1039;
    localparam logic [7:0]  OPT_RESET    = 8'h10;
    localparam logic [7:0]  CTRL_RESET   = 8'h80;
    localparam logic [7:0]  OPT_PROT_MSK = 8'h37;
    localparam int          CTRL_CCF     = 7;
    localparam int          CTRL_SCAN    = 5;
    localparam int          CTRL_MULTI_CHANNEL_MODE    = 4;
    localparam int          OPT_PWR      = 7;
    localparam int          OPT_CONVERTER_CLOCK_SELECT     = 6;
    localparam int          PROT_CYCLES  = 64;
    localparam int          CONV_CYCLES  = 32;
    localparam int          SAMPLE_CYCLES = 12;
    localparam int          CLK_HZ       = 200_000_000;
    localparam int          STOP_WAIT_MS = 10;
    localparam int          PWR_WAIT_US  = 100;
    localparam int          PWR_WAIT_CYC = PWR_WAIT_US * (CLK_HZ / 1_000_000);
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_TRIAL  = 2'b11,
        ST_HOLD   = 2'b10
    } conv_state_t;
endpackage

// [adc_sequence_control.sv]
// Converter sequencing, control registers and classic Wishbone slave
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_control
    import adc_seq_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [7:0]  wb_dat_i,
    output logic      [7:0]  wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic        wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        special_mode_i,
    input  wire logic        low_power_i,
    input  wire logic        comp_i,
    output logic      [3:0]  mux_sel_o,
    output logic      [7:0]  dac_code_o,
    output logic             sample_o,
    output logic             converter_power_up_o,
    output logic             converter_clock_select_o,
    output logic             irq_edge_only_o,
    output logic             stop_exit_delay_o,
    output logic             clock_monitor_on_o,
    output logic             forced_clock_monitor_o,
    output logic      [1:0]  watchdog_rate_o
);
    //--------------------------------------------------------------------------
    // Bus decode
    //--------------------------------------------------------------------------
    logic        req;
    logic        hit;
    logic        wr_ctrl;
    logic        wr_opt;
    logic        rd_now;
    logic        ack_q;
    logic        err_q;
    logic [7:0]  rdat_q;
    logic [6:0]  ctrl_q;
    logic        ccf_q;
    logic [7:0]  opt_q;
    logic        prot_done_q;
    logic [6:0]  boot_cnt_q;
    logic [7:0]  res_q [4];
    logic [7:0]  rd_mux;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
    always_comb begin
        hit    = 1'b1;
        rd_mux = 8'h00;
        unique case (wb_adr_i)
            CTRL_OFFSET: rd_mux = {ccf_q, 1'b0, ctrl_q[5:0]};
            RES1_OFFSET: rd_mux = res_q[0];
            RES2_OFFSET: rd_mux = res_q[1];
            RES3_OFFSET: rd_mux = res_q[2];
            RES4_OFFSET: rd_mux = res_q[3];
            OPT_OFFSET:  rd_mux = opt_q;
            default:     hit    = 1'b0;
        endcase
    end
    assign wr_ctrl = req & hit & wb_we_i & wb_sel_i &
                     (wb_adr_i == CTRL_OFFSET);
    assign wr_opt  = req & hit & wb_we_i & wb_sel_i &
                     (wb_adr_i == OPT_OFFSET);
    assign rd_now  = req & ~wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            err_q  <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            ack_q  <= req & hit;
            err_q  <= req & ~hit;
            rdat_q <= (req & hit & ~wb_we_i) ? rd_mux : 8'h00;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;

    //--------------------------------------------------------------------------
    // Options register
    //--------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_cnt_q <= 7'h00;
        end else if (boot_cnt_q != 7'(PROT_CYCLES)) begin
            boot_cnt_q <= boot_cnt_q + 7'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_q       <= OPT_RESET;
            prot_done_q <= 1'b0;
        end else if (wr_opt) begin
            // Protected bits lock after one write or the boot window, except in special mode
            if (special_mode_i ||
                (!prot_done_q && boot_cnt_q < 7'(PROT_CYCLES))) begin
                opt_q       <= wb_dat_i;
                prot_done_q <= 1'b1;
            end else begin
                opt_q <= (opt_q & OPT_PROT_MSK) |
                         (wb_dat_i & ~OPT_PROT_MSK);
            end
        end
    end
    assign converter_power_up_o     = opt_q[OPT_PWR];
    assign converter_clock_select_o = opt_q[OPT_CONVERTER_CLOCK_SELECT];
    assign irq_edge_only_o          = opt_q[5];
    assign stop_exit_delay_o        = opt_q[4];
    assign clock_monitor_on_o       = opt_q[3];
    assign forced_clock_monitor_o   = opt_q[2];
    assign watchdog_rate_o          = opt_q[1:0];

    //--------------------------------------------------------------------------
    // Sequencer
    //--------------------------------------------------------------------------
    conv_state_t st_q;
    logic [4:0]  cyc_q;
    logic [1:0]  idx_q;
    logic [2:0]  bit_q;
    logic [7:0]  sar_q;
    logic        start_q;
    logic        pend_q;
    logic [7:0]  pend_val_q;
    logic [1:0]  pend_idx_q;
    logic        done_pend_q;
    logic        run;
    logic [7:0]  trial;
    logic [7:0]  final_sar;

    // Start one clock after the control write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_q <= 1'b0;
        end else begin
            start_q <= wr_ctrl;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RESET[6:0];
        end else if (wr_ctrl) begin
            ctrl_q <= {1'b0, wb_dat_i[5:0]};
        end
    end

    assign run       = opt_q[OPT_PWR] & ~low_power_i;
    assign trial     = sar_q | (8'h80 >> bit_q);
    assign final_sar = comp_i ? trial : sar_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q  <= ST_IDLE;
            cyc_q <= 5'h00;
            idx_q <= 2'h0;
            bit_q <= 3'h0;
            sar_q <= 8'h00;
        end else if (wr_ctrl) begin
            st_q <= ST_IDLE;
        end else if (start_q) begin
            st_q  <= ST_SAMPLE;
            cyc_q <= 5'h00;
            idx_q <= 2'h0;
            sar_q <= 8'h00;
        end else if (st_q != ST_IDLE && !run) begin
            st_q  <= ST_HOLD;
            cyc_q <= 5'h00;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    st_q <= ST_IDLE;
                end
                ST_HOLD: begin
                    // Resample the suspended channel from scratch
                    st_q  <= ST_SAMPLE;
                    cyc_q <= 5'h00;
                    sar_q <= 8'h00;
                end
                ST_SAMPLE: begin
                    cyc_q <= cyc_q + 5'h01;
                    if (cyc_q == 5'(SAMPLE_CYCLES - 1)) begin
                        st_q  <= ST_TRIAL;
                        bit_q <= 3'h0;
                        sar_q <= 8'h00;
                    end
                end
                ST_TRIAL: begin
                    cyc_q <= cyc_q + 5'h01;
                    if (cyc_q[0]) begin
                        sar_q <= final_sar;
                        bit_q <= bit_q + 3'h1;
                    end
                    if (cyc_q == 5'(CONV_CYCLES - 1)) begin
                        idx_q <= idx_q + 2'h1;
                        cyc_q <= 5'h00;
                        sar_q <= 8'h00;
                        if (idx_q == 2'h3 && !ctrl_q[CTRL_SCAN]) begin
                            st_q <= ST_IDLE;
                        end else begin
                            st_q <= ST_SAMPLE;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Results wait while a read is answered, so no read sees a torn update
    logic conv_end;
    assign conv_end = (st_q == ST_TRIAL) & run & ~wr_ctrl & ~start_q &
                      (cyc_q == 5'(CONV_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q      <= 1'b0;
            pend_val_q  <= 8'h00;
            pend_idx_q  <= 2'h0;
            done_pend_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                res_q[i] <= 8'h00;
            end
        end else begin
            if (conv_end) begin
                pend_q      <= 1'b1;
                pend_val_q  <= final_sar;
                pend_idx_q  <= idx_q;
                done_pend_q <= (idx_q == 2'h3);
            end else if (pend_q && !rd_now) begin
                res_q[pend_idx_q] <= pend_val_q;
                pend_q            <= 1'b0;
                done_pend_q       <= 1'b0;
            end
            if (wr_ctrl) begin
                pend_q      <= 1'b0;
                done_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ccf_q <= CTRL_RESET[CTRL_CCF];
        end else if (pend_q && !rd_now && done_pend_q && !wr_ctrl) begin
            ccf_q <= 1'b1;
        end else if (wr_ctrl) begin
            ccf_q <= 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // Analog core drive
    //--------------------------------------------------------------------------
    logic [3:0] mux_q;
    logic       smp_q;
    logic [7:0] dac_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mux_q <= 4'h0;
            smp_q <= 1'b0;
            dac_q <= 8'h00;
        end else begin
            if (ctrl_q[CTRL_MULTI_CHANNEL_MODE]) begin
                mux_q <= {ctrl_q[3:2], idx_q};
            end else begin
                mux_q <= ctrl_q[3:0];
            end
            smp_q <= (st_q == ST_SAMPLE) & run;
            dac_q <= (st_q == ST_TRIAL) ? trial : 8'h00;
        end
    end
    assign mux_sel_o  = mux_q;
    assign sample_o   = smp_q;
    assign dac_code_o = dac_q;
endmodule
`default_nettype wire

// [analog_core_model.sv]
// Behavioural analog core: held channel level against trial code
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
    input  wire logic [0:0]   clk_i,
    input  wire logic [3:0]   mux_sel_i,
    input  wire logic [7:0]   dac_code_i,
    input  wire logic         sample_i,
    input  wire logic [127:0] levels_i,
    output logic              comp_o
);
    logic [7:0] held_q;
    // Tracks the input only while sampling, like the hold array
    always_ff @(posedge clk_i) begin
        if (sample_i) begin
            held_q <= levels_i[mux_sel_i*8 +: 8];
        end
    end
    assign comp_o = (held_q >= dac_code_i);
endmodule
`default_nettype wire

// [adc_seq_props.sv]
// Bus and sequencing properties of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_props
    import adc_seq_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic        wb_we_i,
    input wire logic        wb_sel_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [7:0]  wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        low_power_i,
    input wire logic        sample_o,
    input wire logic        converter_power_up_o
);
    //--------------------------------
    // Helpers and properties
    //--------------------------------
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire hit = (wb_adr_i >= CTRL_OFFSET && wb_adr_i <= RES4_OFFSET)
             || wb_adr_i == OPT_OFFSET;
    wire cwr = req & wb_we_i & wb_sel_i & (wb_adr_i == CTRL_OFFSET);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_map_ack: assert property (req && hit |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acked");
    a_unmap_err: assert property (req && !hit |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 8'h00)
        else $error("read data outside ack");
    a_ctrl_bit6: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == CTRL_OFFSET |-> !wb_dat_o[6]) else $error("bit 6 set");
    a_lp_holds: assert property (low_power_i[*3] |-> !sample_o)
        else $error("sampling while suspended");
    a_pwr_off: assert property (!converter_power_up_o[*3] |-> !sample_o)
        else $error("sampling while powered down");
    a_start_seq: assert property (cwr && converter_power_up_o
        ##0 !low_power_i[*4] |-> sample_o || $past(sample_o))
        else $error("no sequence after write");
    cover property (cwr);
    cover property (req && !hit);
    cover property (low_power_i && sample_o);
endmodule
bind adc_sequence_control adc_seq_props u_props (.clk_i, .rst_i,
    .wb_adr_i, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .low_power_i, .sample_o, .converter_power_up_o);
`default_nettype wire

// [tb_adc_sequence_control.sv]
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sequence_control;
    import adc_seq_pkg::*;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic [15:0]  adr = 16'h0000;
    logic [7:0]   wdat = 8'h00;
    logic         we = 1'b0;
    logic         cyc = 1'b0;
    logic         spc = 1'b0;
    logic         lp = 1'b0;
    logic         sel = 1'b1;
    logic [7:0]   ov;
    logic [127:0] lvl = '0;
    logic [7:0]   rdat, dac, q;
    logic [3:0]   mux;
    logic         ack, err, smp, comp, eb;
    int           errors = 0;
    int           compares = 0;
    int           expv[4];
    always #2.5 clk_i = ~clk_i;
    adc_sequence_control uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack), .wb_err_o(err),
        .special_mode_i(spc), .low_power_i(lp), .comp_i(comp),
        .mux_sel_o(mux), .dac_code_o(dac), .sample_o(smp),
        .converter_power_up_o(ov[7]), .converter_clock_select_o(ov[6]),
        .irq_edge_only_o(ov[5]), .stop_exit_delay_o(ov[4]),
        .clock_monitor_on_o(ov[3]), .forced_clock_monitor_o(ov[2]),
        .watchdog_rate_o(ov[1:0]));
    analog_core_model core (.clk_i(clk_i), .mux_sel_i(mux), .dac_code_i(dac),
        .sample_i(smp), .levels_i(lvl), .comp_o(comp));
    //--------------------------------
    // Tasks
    //--------------------------------
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        q = rdat;
        eb = err;
        cyc <= 1'b0;
        if (n >= 50) begin
            errors++;
            stop_test();
        end
    endtask
    task automatic wait_ccf();
        int n;
        n = 0;
        do begin
            bus(1'b0, CTRL_OFFSET, 8'h00);
            n++;
        end while (q[7] !== 1'b1 && n < 300);
        if (q[7] !== 1'b1) begin
            errors++;
            stop_test();
        end
    endtask
    // Fixed reference levels so full and zero scale come up every run
    task automatic newlvl();
        for (int i = 0; i < 16; i++) lvl[i*8 +: 8] <= 8'($urandom);
        lvl[103:96] <= 8'hFF;
        lvl[111:104] <= 8'h00;
        lvl[119:112] <= 8'h80;
    endtask
    task automatic run(input logic [7:0] c, input logic susp);
        logic [3:0] ch;
        bus(1'b1, CTRL_OFFSET, c);
        bus(1'b0, CTRL_OFFSET, 8'h00);
        chk(q, {2'b00, c[5:0]});
        if (susp) begin
            repeat (20) @(posedge clk_i);
            lp <= 1'b1;
            repeat (50) @(posedge clk_i);
            newlvl();
            lp <= 1'b0;
        end
        for (int k = 0; k < 2; k++) begin
            if (k == 0) wait_ccf();
            else repeat (10 * CONV_CYCLES) @(posedge clk_i);
            if (k == 0) chk(q, {2'b10, c[5:0]});
            for (int i = 0; i < 4; i++) begin
                ch = c[4] ? {c[3:2], 2'(i)} : c[3:0];
                if (k == 0 || c[5]) expv[i] = int'(lvl[ch*8 +: 8]);
                bus(1'b0, RES1_OFFSET + 16'(i), 8'h00);
                chk(q, 8'(expv[i]));
            end
            if (k == 0) newlvl();
        end
        $display("test %h done", c);
    endtask
    //--------------------------------
    // Sequence
    //--------------------------------
    initial begin
        void'($urandom(32'h26A72541));
        newlvl();
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, CTRL_OFFSET, 8'h00);
        chk(q, 8'h80);
        bus(1'b0, OPT_OFFSET, 8'h00);
        chk(q, 8'h10);
        bus(1'b1, OPT_OFFSET, 8'h93);
        bus(1'b1, OPT_OFFSET, 8'h80);
        bus(1'b0, OPT_OFFSET, 8'h00);
        chk(q, 8'h93);
        spc <= 1'b1;
        bus(1'b1, OPT_OFFSET, 8'h80);
        bus(1'b0, OPT_OFFSET, 8'h00);
        chk(q, 8'h80);
        spc <= 1'b0;
        chk(ov, 8'h80);
        // Write with byte select low must be acked and ignored
        sel <= 1'b0;
        bus(1'b1, OPT_OFFSET, 8'h00);
        sel <= 1'b1;
        bus(1'b0, OPT_OFFSET, 8'h00);
        chk(q, 8'h80);
        $display("test options done");
        repeat (PWR_WAIT_CYC) @(posedge clk_i);
        for (int m = 0; m < 4; m++) run({2'b00, m[1], m[0], 4'($urandom)}, 1'b0);
        bus(1'b1, CTRL_OFFSET, 8'h03);
        repeat (CONV_CYCLES + 8) @(posedge clk_i);
        run(8'h07, 1'b0);
        run(8'h1C, 1'b1);
        bus(1'b1, RES2_OFFSET, 8'h55);
        bus(1'b0, RES2_OFFSET, 8'h00);
        chk(q, 8'(expv[1]));
        bus(1'b0, 16'h1035, 8'h00);
        chk({7'h00, eb}, 8'h01);
        $display("test access done");
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire
